// ==== scirx_pkg.sv ====
// Purpose: shared constants and types of the serial receiver block
// Assumes: 32-bit APB register window, 16x oversampling
// Notes: offsets are byte addresses of aligned words
package scirx_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // control bits
  localparam logic [7:0] ADDR_IRQEN = 8'h04;  // interrupt enables
  localparam logic [7:0] ADDR_STAT = 8'h08;  // status flags
  localparam logic [7:0] ADDR_DATA = 8'h0c;  // received character
  localparam logic [7:0] ADDR_BAUD = 8'h10;  // tick divisor
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int C_EN = 0;  // module enable
  localparam int C_RXEN = 1;  // receiver enable
  localparam int C_NINE = 2;  // 9-bit characters
  localparam int C_WAKE = 3;  // standby_exit_select
  localparam int C_IDLE_COUNT_BEGIN_SELECT = 4;  // idle_count_begin_select
  localparam int C_PEN = 5;  // parity enable
  localparam int C_PODD = 6;  // odd parity
  localparam int C_STBY = 7;  // receiver_standby
  localparam int C_BCA = 8;  // break_clear_allow
  localparam int CTRL_W = 9;
  localparam int F_RF = 0;  // receive_full_flag
  localparam int F_IDLE = 1;  // idle flag
  localparam int F_OVR = 2;  // overrun_flag
  localparam int F_NF = 3;  // noise_flag
  localparam int F_FE = 4;  // framing_fault_flag
  localparam int F_PE = 5;  // parity_fault_flag
  localparam int NFLAG = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [15:0] BAUD_RST = 16'h0019;
  // ----------------------------------------
  // oversample positions (0 is the first tick of a bit)
  // ----------------------------------------
  localparam logic [3:0] RT3 = 4'h2;
  localparam logic [3:0] RT5 = 4'h4;
  localparam logic [3:0] RT7 = 4'h6;
  localparam logic [3:0] RT8 = 4'h7;
  localparam logic [3:0] RT9 = 4'h8;
  localparam logic [3:0] RT10 = 4'h9;
  localparam logic [3:0] RT16 = 4'hf;
  localparam logic [3:0] IDLE_ONES_8 = 4'ha;  // 10 ones
  localparam logic [3:0] IDLE_ONES_9 = 4'hb;  // 11 ones
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam int STOP_TICKS_8 = 9 * 16 + 10;
  localparam int STOP_TICKS_9 = 10 * 16 + 10;
  typedef enum logic [3:0] {
    ST_HUNT = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } scirx_state_t;
endpackage : scirx_pkg

// ==== scirx_receiver.sv ====
// Purpose: receiver control, wakeup and status flags of an async serial port
// Assumes: APB slave, mclk 100 MHz, rxd pin asynchronous to mclk
// Notes: transmitter framing is not part of this block; txd held high while enabled, port_tx_data when disabled
module scirx_receiver
  import scirx_pkg::*;
(
  input wire logic mclk,  // module clock
  input wire logic rst_n,  // async reset, active low
  input wire logic psel,  // apb select
  input wire logic penable,  // apb access phase
  input wire logic pwrite,  // apb direction
  input wire logic [7:0] paddr,  // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,  // apb read data
  output logic pready,  // apb ready
  output logic pslverr,  // apb error, unmapped address
  input wire logic rxd_pin,  // serial input pin level
  input wire logic port_tx_data,  // port data when module disabled
  input wire logic pin_dir_tx,  // pin_direction_reg bit of output pin
  input wire logic pin_dir_rx,  // pin_direction_reg bit of input pin
  input wire logic stop_mode,  // processor in stop mode
  input wire logic dbg_break,  // debug break state
  output logic txd_out,  // serial output pin value
  output logic txd_oe,  // serial output pin enable
  output logic rxd_oe,  // input pin output enable
  output logic irq_rx,  // receiver interrupt request
  output logic irq_err,  // error interrupt request
  output logic wake_req  // wake request to processor
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3
  function automatic logic mixed3(input logic a, input logic b, input logic c);
    mixed3 = (a | b | c) & ~(a & b & c);
  endfunction : mixed3

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;  // control bits
  logic [5:0] irqen_ff;  // enables, flag order
  logic [15:0] baud_ff;  // tick divisor
  logic [NFLAG-1:0] flags_ff;  // status flags
  logic [NFLAG-1:0] arm_ff;  // first step of clear seen
  logic [8:0] data_ff;  // serial_data_buffer
  logic [31:0] prdata_ff;  // read data
  logic pready_ff;  // ready
  logic pslverr_ff;  // error
  logic [1:0] rxd_sync_ff;  // pin synchroniser
  logic [15:0] div_ff;  // divisor counter
  logic tick_ff;  // oversample_tick
  scirx_state_t st_ff;  // receive state
  logic [3:0] rt_ff;  // tick within bit
  logic [2:0] hist_ff;  // last three line samples
  logic [1:0] smp_ff;  // held samples
  logic [3:0] bit_ff;  // data bits taken
  logic [8:0] shreg_ff;  // shift register
  logic noise_ff;  // noise seen in character
  logic [3:0] ones_ff;  // consecutive ones
  logic idle_done_ff;  // idle already reported
  logic [7:0] ch_cnt_ff;  // ticks since start edge
  logic txd_out_ff, txd_oe_ff, rxd_oe_ff;  // pin outputs
  logic irq_rx_ff, irq_err_ff, wake_ff;  // requests

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic setup, acc, line, rx_on, sw_ok, nine;
  logic [3:0] nbits, ones_need;
  logic unmapped;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_ff;
  assign unmapped = ~(paddr inside {ADDR_CTRL, ADDR_IRQEN, ADDR_STAT, ADDR_DATA, ADDR_BAUD});
  assign rx_on = ctrl_ff[C_EN] & ctrl_ff[C_RXEN];
  // pin used as input whatever its direction
  assign line = rx_on ? rxd_sync_ff[1] : 1'b1;
  assign nine = ctrl_ff[C_NINE];
  assign nbits = nine ? DATA_BITS_9 : DATA_BITS_8;
  assign ones_need = nine ? IDLE_ONES_9 : IDLE_ONES_8;
  // clears allowed in break only with allow bit
  assign sw_ok = ~dbg_break | ctrl_ff[C_BCA];

  // ----------------------------------------
  // apb read path, registered answer
  // ----------------------------------------
  // answer comes in the first access cycle: no wait states
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & unmapped;
      if (setup & ~pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata_ff <= {23'h000000, ctrl_ff};
          ADDR_IRQEN: prdata_ff <= {26'h0000000, irqen_ff};
          ADDR_STAT: prdata_ff <= {26'h0000000, flags_ff};
          ADDR_DATA: prdata_ff <= {23'h000000, data_ff};
          ADDR_BAUD: prdata_ff <= {16'h0000, baud_ff};
          default: prdata_ff <= 32'h0000_0000;  // unmapped reads zero
        endcase
      end
    end
  end

  // ----------------------------------------
  // pin synchroniser and tick generator
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync_ff <= 2'b11;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[0], rxd_pin};
    end
  end

  // stop mode freezes the divider: no ticks, so the receiver holds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (stop_mode) begin
      tick_ff <= 1'b0;
    end else if (div_ff == 16'h0000) begin
      // tick at sixteen times the baud rate
      div_ff <= baud_ff;
      tick_ff <= ctrl_ff[C_EN];
    end else begin
      div_ff <= div_ff - 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // bit recovery
  // ----------------------------------------
  logic rtick, start_edge, start_bad, bit_val, char_done, stop_ok;
  logic [8:0] chr;
  // no ticks in stop mode, state preserved
  assign rtick = tick_ff & ~stop_mode;
  assign start_edge = rtick & st_ff == ST_HUNT & ~line & hist_ff == 3'b111;
  assign start_bad = maj3(smp_ff[1], smp_ff[0], line);
  assign bit_val = maj3(smp_ff[1], smp_ff[0], line);
  assign stop_ok = bit_val;
  // stop sample at its tenth tick
  assign char_done = rtick & st_ff == ST_STOP & rt_ff == RT10;
  assign chr = nine ? shreg_ff : {1'b0, shreg_ff[8:1]};

  // start search, verification, data and stop sampling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_HUNT;
      rt_ff <= 4'h0;
      hist_ff <= 3'b111;
      smp_ff <= 2'b00;
      bit_ff <= 4'h0;
      shreg_ff <= 9'h000;
      noise_ff <= 1'b0;
    end else if (rtick) begin
      rt_ff <= rt_ff + 4'h1;
      hist_ff <= {hist_ff[1:0], line};
      if (rt_ff == RT3 || rt_ff == RT8) smp_ff[1] <= line;
      if (rt_ff == RT5 || rt_ff == RT9) smp_ff[0] <= line;
      case (st_ff)
        ST_HUNT: begin
          if (start_edge) begin
            st_ff <= ST_START;
            rt_ff <= 4'h1;  // edge tick counts as the first
            noise_ff <= 1'b0;
          end
        end
        ST_START: begin
          if (rt_ff == RT7) begin
            if (start_bad) begin
              st_ff <= ST_HUNT;  // false start, search again
              hist_ff <= 3'b000;
            end else begin
              noise_ff <= noise_ff | mixed3(smp_ff[1], smp_ff[0], line);
            end
          end
          if (rt_ff == RT10) noise_ff <= noise_ff | (smp_ff[1] | smp_ff[0] | line);
          if (rt_ff == RT16) begin
            st_ff <= ST_DATA;
            bit_ff <= 4'h0;
          end
        end
        ST_DATA: begin
          if (rt_ff == RT10) begin
            noise_ff <= noise_ff | mixed3(smp_ff[1], smp_ff[0], line);
            shreg_ff <= {bit_val, shreg_ff[8:1]};
            bit_ff <= bit_ff + 4'h1;
          end
          if (rt_ff == RT16 && bit_ff == nbits) st_ff <= ST_STOP;
        end
        ST_STOP: begin
          if (rt_ff == RT10) begin
            st_ff <= ST_HUNT;
            hist_ff <= {3{stop_ok}};
          end
        end
        default: st_ff <= ST_HUNT;
      endcase
    end
  end

  // ticks since the start edge, read by the timing checks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ch_cnt_ff <= 8'h00;
    end else if (start_edge) begin
      ch_cnt_ff <= 8'h01;
    end else if (rtick && st_ff != ST_HUNT) begin
      ch_cnt_ff <= ch_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // idle line counting
  // ----------------------------------------
  logic idle_hit, idle_count_begin_select;
  assign idle_count_begin_select = ctrl_ff[C_IDLE_COUNT_BEGIN_SELECT];
  assign idle_hit = rx_on & ~idle_done_ff & ones_need == ones_ff;
  // ones counted from start bit or from stop bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ones_ff <= 4'h0;
      idle_done_ff <= 1'b0;
    end else begin
      if (idle_hit) idle_done_ff <= 1'b1;
      if (start_edge) begin
        ones_ff <= 4'h0;
        idle_done_ff <= 1'b0;
      end else if (rtick && rt_ff == RT10 && st_ff == ST_DATA) begin
        ones_ff <= (bit_val & ~idle_count_begin_select) ? ones_ff + 4'h1 : 4'h0;
      end else if (char_done) begin
        ones_ff <= (stop_ok & ~idle_count_begin_select) ? ones_ff + 4'h1 : 4'h0;
      end else if (rtick && rt_ff == RT16 && st_ff == ST_HUNT && ones_ff != ones_need) begin
        ones_ff <= line ? ones_ff + 4'h1 : 4'h0;
      end
    end
  end

  // ----------------------------------------
  // flag events and control register
  // ----------------------------------------
  logic stby, addr_wake, idle_wake, accept;
  logic [NFLAG-1:0] ev, clr;
  assign stby = ctrl_ff[C_STBY];
  assign addr_wake = char_done & stby & ctrl_ff[C_WAKE] & shreg_ff[8];
  assign idle_wake = idle_hit & stby & ~ctrl_ff[C_WAKE];
  assign accept = char_done & (~stby | addr_wake);
  always_comb begin
    ev = '0;
    // full flag on transfer to buffer
    ev[F_RF] = accept & ~flags_ff[F_RF];
    ev[F_OVR] = accept & flags_ff[F_RF];
    ev[F_NF] = accept & (noise_ff | mixed3(smp_ff[1], smp_ff[0], line));
    ev[F_FE] = ev[F_RF] & ~stop_ok;
    ev[F_PE] = ev[F_RF] & ctrl_ff[C_PEN] & ((^chr) != ctrl_ff[C_PODD]);
    ev[F_IDLE] = idle_hit & ~stby;
  end
  // second step clears only what the first step saw
  assign clr = (acc && !pwrite && paddr == ADDR_DATA && sw_ok) ? arm_ff : '0;

  // status flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
      arm_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~clr) | ev;
      if (acc && !pwrite && paddr == ADDR_STAT && sw_ok) arm_ff <= prdata_ff[NFLAG-1:0];
      else if (|clr) arm_ff <= '0;
    end
  end

  // buffer only loads when the previous character was read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 9'h000;
    end else if (ev[F_RF]) begin
      data_ff <= chr;
    end
  end

  // software writes win over a wake clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      irqen_ff <= 6'h00;
      baud_ff <= BAUD_RST;
    end else if (acc && pwrite && paddr == ADDR_CTRL) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end else begin
      if (addr_wake | idle_wake) ctrl_ff[C_STBY] <= 1'b0;
      if (acc && pwrite && paddr == ADDR_IRQEN) irqen_ff <= pwdata[5:0];
      if (acc && pwrite && paddr == ADDR_BAUD) baud_ff <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // requests and pins
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_rx_ff <= 1'b0;
      irq_err_ff <= 1'b0;
      wake_ff <= 1'b0;
      txd_out_ff <= 1'b1;
      txd_oe_ff <= 1'b0;
      rxd_oe_ff <= 1'b0;
    end else begin
      irq_rx_ff <= ~stby & |(flags_ff[F_IDLE:F_RF] & irqen_ff[F_IDLE:F_RF]);
      irq_err_ff <= |(flags_ff[F_PE:F_OVR] & irqen_ff[F_PE:F_OVR]);
      wake_ff <= ~stop_mode & (irq_rx_ff | irq_err_ff);
      txd_oe_ff <= ctrl_ff[C_EN] | pin_dir_tx;
      txd_out_ff <= ctrl_ff[C_EN] | port_tx_data;
      rxd_oe_ff <= ~ctrl_ff[C_EN] & pin_dir_rx;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_rx = irq_rx_ff;
  assign irq_err = irq_err_ff;
  assign wake_req = wake_ff;
  assign txd_out = txd_out_ff;
  assign txd_oe = txd_oe_ff;
  assign rxd_oe = rxd_oe_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence full_set_s;
    ev[F_RF] & irqen_ff[F_RF] & ~stby;
  endsequence
  sequence rx_req_s;
    ##1 irq_rx;
  endsequence
  stop_time_8_a: assert property (char_done & ~nine |-> ch_cnt_ff == STOP_TICKS_8 - 1)
    else $error("8-bit stop sample off time");
  stop_time_9_a: assert property (char_done & nine |-> ch_cnt_ff == STOP_TICKS_9 - 1)
    else $error("9-bit stop sample off time");
  standby_gate_a: assert property (stby |=> ~irq_rx)
    else $error("receiver request during standby");
  addr_wake_a: assert property (addr_wake & ~flags_ff[F_RF] |=> ~stby & flags_ff[F_RF])
    else $error("address mark did not wake");
  idle_wake_a: assert property (idle_wake |=> ~stby & ~$rose(flags_ff[F_IDLE]))
    else $error("idle wake misbehaved");
  full_irq_a: assert property (full_set_s ##1 ~stby |-> rx_req_s)
    else $error("full flag raised no request");
  overrun_keep_a: assert property (ev[F_OVR] |=> flags_ff[F_OVR] & $stable(data_ff))
    else $error("overrun lost old character");
  fe_with_rf_a: assert property ($rose(flags_ff[F_FE]) |-> $rose(flags_ff[F_RF]))
    else $error("framing flag without full flag");
  break_hold_a: assert property (dbg_break & ~ctrl_ff[C_BCA] & ev == '0 |=> $stable(flags_ff))
    else $error("status changed in break");
  txd_drive_a: assert property (ctrl_ff[C_EN] |=> txd_oe)
    else $error("output pin not driven");
  stop_nowake_a: assert property (stop_mode |=> ~wake_req)
    else $error("wake in stop mode");
endmodule : scirx_receiver

// ==== scirx_tx_model.sv ====
// Purpose: remote async transmitter that drives the serial input line
// Assumes: divisor 0 in the block, so one bit time is BIT_CYC mclk
// Notes: the line idles high between frames, as an async link does
module scirx_tx_model #(
  parameter int BIT_CYC = 16  // mclk per bit time
) (
  input wire logic mclk,  // bench clock
  input wire logic nz_en,  // flip the middle sample of data bit 0
  output logic line  // serial line level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // frame driver
  // ----------------------------------------
  initial line = 1'b1;  // idle level before the first frame
  // sixteen ticks a bit
  // start bit, nb data bits lsb first, then one stop bit of level stp
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    int i;
    int k;
    for (i = -1; i <= nb; i++) begin
      @(posedge mclk);
      line <= (i < 0) ? 1'b0 : ((i == nb) ? stp : d[i]);
      for (k = 1; k < BIT_CYC; k++) begin
        @(posedge mclk);
        // one-cycle glitch on the middle sample: majority keeps the bit, noise is seen
        if (nz_en && i == 0 && (k == BIT_CYC / 2 || k == BIT_CYC / 2 + 1)) line <= ~line;
      end
    end
    // back to idle, so a zero stop bit still ends cleanly
    @(posedge mclk);
    line <= 1'b1;
  endtask : send
endmodule : scirx_tx_model

// ==== test_sci_receiver_wakeup_flags.sv ====
// Purpose: self-checking bench of receiver flags, wakeup and pins
// Assumes: divisor 0, one oversample tick per mclk
// Notes: expectations come from flag positions and frame timing
module test_sci_receiver_wakeup_flags
  import scirx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;  // 100 MHz
  logic rst_n, psel, penable, pwrite, pready, pslverr, rxd_line, err_v;
  logic [7:0] paddr;  // byte address
  logic [31:0] pwdata, prdata, rd_v;  // bus data
  logic port_tx_data, pin_dir_tx, pin_dir_rx, stop_mode, dbg_break, nz_en;
  logic txd_out, txd_oe, rxd_oe, irq_rx, irq_err, wake_req;
  int mismatches = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  scirx_receiver dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_line), .port_tx_data(port_tx_data), .pin_dir_tx(pin_dir_tx), .pin_dir_rx(pin_dir_rx),
    .stop_mode(stop_mode), .dbg_break(dbg_break), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_oe(rxd_oe),
    .irq_rx(irq_rx), .irq_err(irq_err), .wake_req(wake_req));
  scirx_tx_model #(.BIT_CYC(16)) tx_u (.mclk(mclk), .nz_en(nz_en), .line(rxd_line));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // an edge passes so the next setup never lands in this time step
    @(posedge mclk);
    if (n >= 20) begin
      mismatches++;
      results();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_v, exp);
  endtask : rd
  // extra edge lets registered outputs follow the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge mclk);
  endtask : wr
  // drain pending idle detection, then status read and data read clear all
  task automatic clr();
    repeat (260) @(posedge mclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    apb(1'b0, ADDR_DATA, 32'h0);
  endtask : clr
  // receiver request must stay low before the stop sample and be up after
  task automatic frame_t(input logic [8:0] d, input int nb, input int lat);
    fork
      tx_u.send(d, nb, 1'b1);
      begin
        repeat (lat - 4) @(posedge mclk);
        chk("irq_rx early", 32'(irq_rx), 32'h0);
        repeat (15) @(posedge mclk);
        chk("irq_rx late", 32'(irq_rx), 32'h1);
      end
    join
  endtask : frame_t
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_tx_data = 1'b0;
    pin_dir_tx = 1'b0;
    pin_dir_rx = 1'b1;
    stop_mode = 1'b0;
    dbg_break = 1'b0;
    nz_en = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_BAUD, 32'h19, "baud reset");
    rd(8'h20, 32'h0, "unmapped");
    chk("slverr", 32'(err_v), 32'h1);
    chk("pins off", {29'h0, txd_oe, rxd_oe, txd_out}, 32'h2);
    wr(ADDR_BAUD, 32'h0);
    wr(ADDR_IRQEN, 32'h1);
    wr(ADDR_CTRL, 32'h3);
    chk("pins on", {29'h0, txd_oe, rxd_oe, txd_out}, 32'h5);
    $display("test pins done");
    frame_t(9'h0a5, 8, STOP_TICKS_8);
    rd(ADDR_STAT, 32'h1, "full");
    rd(ADDR_DATA, 32'h0a5, "data 8");
    rd(ADDR_STAT, 32'h0, "cleared");
    wr(ADDR_IRQEN, 32'h3);
    repeat (200) @(posedge mclk);
    rd(ADDR_STAT, 32'h2, "idle");
    chk("irq idle", 32'(irq_rx), 32'h1);
    clr();
    wr(ADDR_CTRL, 32'h7);
    wr(ADDR_IRQEN, 32'h1);
    frame_t(9'h1a5, 9, STOP_TICKS_9);
    rd(ADDR_DATA, 32'h1a5, "data 9");
    clr();
    $display("test timing done");
    wr(ADDR_CTRL, 32'h3);
    tx_u.send(9'h0ff, 8, 1'b1);
    repeat (40) @(posedge mclk);
    rd(ADDR_STAT, 32'h3, "idle after start");
    clr();
    wr(ADDR_CTRL, 32'h13);
    tx_u.send(9'h0ff, 8, 1'b1);
    repeat (40) @(posedge mclk);
    rd(ADDR_STAT, 32'h1, "idle after stop");
    clr();
    $display("test idle done");
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_IRQEN, 32'h5);
    tx_u.send(9'h011, 8, 1'b1);
    tx_u.send(9'h022, 8, 1'b1);
    rd(ADDR_STAT, 32'h5, "overrun");
    chk("irq_err", 32'(irq_err), 32'h1);
    chk("wake", 32'(wake_req), 32'h1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wake stop", 32'(wake_req), 32'h0);
    stop_mode <= 1'b0;
    rd(ADDR_DATA, 32'h011, "old kept");
    clr();
    tx_u.send(9'h05a, 8, 1'b0);
    rd(ADDR_STAT, 32'h11, "framing");
    clr();
    wr(ADDR_CTRL, 32'h23);
    tx_u.send(9'h001, 8, 1'b1);
    rd(ADDR_STAT, 32'h21, "parity bad");
    clr();
    tx_u.send(9'h081, 8, 1'b1);
    rd(ADDR_STAT, 32'h1, "parity good");
    clr();
    wr(ADDR_CTRL, 32'h63);
    nz_en <= 1'b1;
    tx_u.send(9'h001, 8, 1'b1);
    nz_en <= 1'b0;
    rd(ADDR_STAT, 32'h9, "noise odd parity");
    rd(ADDR_DATA, 32'h001, "noisy data");
    clr();
    $display("test errors done");
    wr(ADDR_CTRL, 32'h8b);
    tx_u.send(9'h012, 8, 1'b1);
    rd(ADDR_STAT, 32'h0, "standby drop");
    tx_u.send(9'h092, 8, 1'b1);
    rd(ADDR_STAT, 32'h1, "mark full");
    rd(ADDR_CTRL, 32'h0b, "mark wake");
    chk("irq awake", 32'(irq_rx), 32'h1);
    wr(ADDR_CTRL, 32'h8b);
    chk("irq standby", 32'(irq_rx), 32'h0);
    clr();
    wr(ADDR_CTRL, 32'h83);
    rd(ADDR_CTRL, 32'h83, "standby kept");
    tx_u.send(9'h000, 8, 1'b1);
    repeat (250) @(posedge mclk);
    rd(ADDR_CTRL, 32'h3, "idle wake");
    rd(ADDR_STAT, 32'h0, "wake no flags");
    $display("test standby done");
    tx_u.send(9'h033, 8, 1'b1);
    repeat (200) @(posedge mclk);
    rd(ADDR_STAT, 32'h3, "armed");
    dbg_break <= 1'b1;
    rd(ADDR_DATA, 32'h033, "break data");
    rd(ADDR_STAT, 32'h3, "protected");
    dbg_break <= 1'b0;
    rd(ADDR_DATA, 32'h033, "second step");
    rd(ADDR_STAT, 32'h0, "after break");
    wr(ADDR_CTRL, 32'h103);
    tx_u.send(9'h000, 8, 1'b1);
    dbg_break <= 1'b1;
    rd(ADDR_STAT, 32'h1, "allow full");
    rd(ADDR_DATA, 32'h000, "allow data");
    dbg_break <= 1'b0;
    rd(ADDR_STAT, 32'h0, "allow cleared");
    $display("test break done");
    results();
  end
endmodule : test_sci_receiver_wakeup_flags
